// [src/cpac_cfg.svh]
// Purpose: Offsets, field positions, reset values and counts of the configuration port access controller
// Assumes: Included by bare name wherever a figure is needed
// Notes:   Definitions only
`ifndef CPAC_CFG_SVH
`define CPAC_CFG_SVH

// Register byte offsets on the AHB-Lite slave
`define CPAC_OFS_SIZE 8'h00
`define CPAC_OFS_CTRL 8'h04
`define CPAC_OFS_STAT 8'h08
`define CPAC_OFS_WOCC 8'h0c
`define CPAC_OFS_ROCC 8'h10
`define CPAC_OFS_REM 8'h14

// Control register field positions
`define CPAC_CTRL_RD 0
`define CPAC_CTRL_LOCK 1
`define CPAC_CTRL_STRM 2
`define CPAC_CTRL_WDIS 3
`define CPAC_CTRL_RDIS 4
`define CPAC_CTRL_W 5
`define CPAC_CTRL_RST 5'h00

// Word counts: 2^30 bytes is 2^28 words, which needs 29 bits
`define CPAC_SIZE_W 29
`define CPAC_SIZE_RST 29'h0

// FIFO shapes
`define CPAC_DATA_W 32
`define CPAC_FIFO_DEPTH 32
`define CPAC_FIFO_AW 5
`define CPAC_OUTST 16
`define CPAC_OUTST_AW 4
`define CPAC_LEN_W 8

// Cycles to stay off the request after release falls
`define CPAC_REL_GAP 2'h3

// Arbitration and primitive pins sit on the block boundary
`define CPAC_EXT_PRIM 1

`endif

// [src/cpac_pkg.sv]
// Purpose: Types shared by the configuration port access controller
// Assumes: cpac_cfg.svh supplies the widths
// Notes:   Used only by scoped names, never imported
`include "cpac_cfg.svh"
package cpac_pkg;
   // Access request state, one-hot
   typedef enum logic [3:0] {
      ARB_IDLE = 4'b0001,
      ARB_REQ = 4'b0010,
      ARB_OFF = 4'b0100,
      ARB_GAP = 4'b1000
   } cpac_arb_t;

   typedef logic [`CPAC_SIZE_W-1:0] cpac_words_t;
endpackage : cpac_pkg

// [src/cpac_fifo.sv]
// Purpose: Small first-word-fall-through FIFO with register storage
// Assumes: Push when full and pop when empty are ignored
// Notes:   single limits occupancy to one word, which is how a FIFO is disabled
`timescale 1ns/10ps
module cpac_fifo #(
   parameter int unsigned W = 32,
   parameter int unsigned DEPTH = 32,
   parameter int unsigned AW = 5
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic single,
   input wire logic push,
   input wire logic [W-1:0] din,
   input wire logic pop,
   output logic [W-1:0] dout,
   output logic full,
   output logic empty,
   output logic [AW:0] count
);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic do_push, do_pop;

   // Flags straight from the occupancy so full rises in the cycle it is reached
   assign full = single ? (cnt_reg != '0) : (cnt_reg == (AW+1)'(DEPTH));
   assign empty = (cnt_reg == '0);
   assign count = cnt_reg;
   assign dout = mem[rptr_reg];
   assign do_push = push && !full;
   assign do_pop = pop && !empty;

   // One storage word per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge hclk) begin
         if (do_push && (wptr_reg == AW'(i))) begin
            mem[i] <= din;
         end
      end
   end

   // Pointer and occupancy next values
   always_comb begin
      wptr_next = wptr_reg;
      rptr_next = rptr_reg;
      cnt_next = cnt_reg;
      if (do_push) begin
         wptr_next = wptr_reg + AW'(1);
      end
      if (do_pop) begin
         rptr_next = rptr_reg + AW'(1);
      end
      if (do_push && !do_pop) begin
         cnt_next = cnt_reg + (AW+1)'(1);
      end else if (do_pop && !do_push) begin
         cnt_next = cnt_reg - (AW+1)'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule : cpac_fifo

// [src/cpac_arb.sv]
// Purpose: Request side of the shared primitive handshake
// Assumes: need and busy come from the primitive sequencer
// Notes:   Request is a flop-decoded state, low from reset
`timescale 1ns/10ps
`include "cpac_cfg.svh"
module cpac_arb (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic need,
   input wire logic busy,
   input wire logic lock,
   input wire logic access_rel,
   output logic access_req
);
   cpac_pkg::cpac_arb_t st_reg, st_next;
   logic [1:0] gap_reg, gap_next;

   assign access_req = (st_reg == cpac_pkg::ARB_REQ);

   // Release wins over need and lock but waits in ARB_REQ until busy clears; lock keeps the request up between transfers
   always_comb begin
      st_next = st_reg;
      gap_next = gap_reg;
      unique case (st_reg)
         cpac_pkg::ARB_IDLE: begin
            if (access_rel) begin
               st_next = cpac_pkg::ARB_OFF;
            end else if (need || lock) begin
               st_next = cpac_pkg::ARB_REQ;
            end
         end
         cpac_pkg::ARB_REQ: begin
            if (access_rel && !busy) begin
               st_next = cpac_pkg::ARB_OFF;
            end else if (!access_rel && !need && !lock && !busy) begin
               st_next = cpac_pkg::ARB_IDLE;
            end
         end
         cpac_pkg::ARB_OFF: begin
            if (!access_rel) begin
               st_next = cpac_pkg::ARB_GAP;
               gap_next = 2'h0;
            end
         end
         cpac_pkg::ARB_GAP: begin
            gap_next = gap_reg + 2'h1;
            if (access_rel) begin
               st_next = cpac_pkg::ARB_OFF;
            end else if (gap_reg == (`CPAC_REL_GAP - 2'h1)) begin
               st_next = cpac_pkg::ARB_IDLE;
            end
         end
         default: begin
            st_next = cpac_pkg::ARB_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= cpac_pkg::ARB_IDLE;
         gap_reg <= 2'h0;
      end else begin
         st_reg <= st_next;
         gap_reg <= gap_next;
      end
   end
endmodule : cpac_arb

// [src/cpac_top.sv]
// Purpose: Configuration port access controller: AHB-Lite control, memory-mapped write and read
//          slaves, stream read master and the shared primitive port
// Assumes: One clock, hclk at 10 MHz; primitive returns read data within the select cycle, captured at its closing edge
// Notes:   Primitive and arbitration pins are always on the boundary
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "cpac_cfg.svh"
module cpac_top (
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite control slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Memory-mapped write slave
   input wire logic mm_awvalid,
   output logic mm_awready,
   input wire logic [7:0] mm_awlen,
   input wire logic mm_wvalid,
   output logic mm_wready,
   input wire logic [31:0] mm_wdata,
   input wire logic mm_wlast,
   output logic mm_bvalid,
   input wire logic mm_bready,
   output logic [1:0] mm_bresp,
   // Memory-mapped read slave
   input wire logic mm_arvalid,
   output logic mm_arready,
   input wire logic [7:0] mm_arlen,
   output logic mm_rvalid,
   input wire logic mm_rready,
   output logic [31:0] mm_rdata,
   output logic mm_rlast,
   output logic [1:0] mm_rresp,
   // Stream read master
   output logic st_tvalid,
   input wire logic st_tready,
   output logic [31:0] st_tdata,
   output logic st_tlast,
   // Shared primitive and its arbiter
   output logic prim_sel_n,
   output logic prim_rd_nwr,
   output logic [31:0] prim_wdata,
   input wire logic [31:0] prim_rdata,
   output logic access_req,
   input wire logic access_gnt,
   input wire logic access_rel,
   output logic gate_prim_clk
);
   localparam int unsigned FAW = `CPAC_FIFO_AW;

   // AHB state
   logic a_go, a_hit;
   logic wr_pend_reg, wr_pend_next;
   logic [7:0] wr_ofs_reg, wr_ofs_next;
   logic [31:0] hrdata_reg, hrdata_next;
   // Software-visible state
   cpac_pkg::cpac_words_t size_reg, size_next, remain_reg, remain_next;
   logic [`CPAC_CTRL_W-1:0] ctrl_reg, ctrl_next;
   // Primitive sequencer state
   logic sel_n_reg, sel_n_next, rd_nwr_reg, rd_nwr_next, cap_pend_reg, cap_pend_next;
   logic [31:0] pwdata_reg, pwdata_next;
   // Bus transaction bookkeeping
   logic [`CPAC_OUTST_AW:0] aw_cnt_reg, aw_cnt_next, b_cnt_reg, b_cnt_next;
   logic [`CPAC_LEN_W-1:0] beat_reg, beat_next;

   logic rd_cmd, strm, owned, wr_go, rd_go, need, busy;
   logic aw_hs, w_hs, w_last, b_hs, r_hs, t_hs;
   logic wf_full, wf_empty, rf_full, rf_empty, aq_full, aq_empty;
   logic [31:0] wf_dout, rf_dout;
   logic [FAW:0] wf_cnt, rf_cnt;
   logic [`CPAC_LEN_W-1:0] aq_len;
   logic [`CPAC_OUTST_AW:0] aq_cnt;
   logic [`CPAC_OUTST_AW+1:0] outst;

   assign rd_cmd = ctrl_reg[`CPAC_CTRL_RD];
   assign strm = ctrl_reg[`CPAC_CTRL_STRM];

   // Write FIFO fed by the write slave, drained by the sequencer
   cpac_fifo #(.W(`CPAC_DATA_W), .DEPTH(`CPAC_FIFO_DEPTH), .AW(FAW)) u_wfifo (
      .hclk(hclk),
      .hresetn(hresetn),
      .single(ctrl_reg[`CPAC_CTRL_WDIS]),
      .push(w_hs),
      .din(mm_wdata),
      .pop(wr_go),
      .dout(wf_dout),
      .full(wf_full),
      .empty(wf_empty),
      .count(wf_cnt)
   );

   // Read FIFO fed by primitive captures, drained by whichever read port is chosen
   cpac_fifo #(.W(`CPAC_DATA_W), .DEPTH(`CPAC_FIFO_DEPTH), .AW(FAW)) u_rfifo (
      .hclk(hclk),
      .hresetn(hresetn),
      .single(ctrl_reg[`CPAC_CTRL_RDIS]),
      .push(cap_pend_reg),
      .din(prim_rdata),
      .pop(r_hs || t_hs),
      .dout(rf_dout),
      .full(rf_full),
      .empty(rf_empty),
      .count(rf_cnt)
   );

   // Burst lengths of accepted read addresses; its depth bounds outstanding reads
   cpac_fifo #(.W(`CPAC_LEN_W), .DEPTH(`CPAC_OUTST), .AW(`CPAC_OUTST_AW)) u_arq (
      .hclk(hclk),
      .hresetn(hresetn),
      .single(1'b0),
      .push(mm_arvalid && mm_arready),
      .din(mm_arlen),
      .pop(r_hs && mm_rlast),
      .dout(aq_len),
      .full(aq_full),
      .empty(aq_empty),
      .count(aq_cnt)
   );

   // Request, release and gap handling
   cpac_arb u_arb (
      .hclk(hclk),
      .hresetn(hresetn),
      .need(need),
      .busy(busy),
      .lock(ctrl_reg[`CPAC_CTRL_LOCK]),
      .access_rel(access_rel),
      .access_req(access_req)
   );

   // AHB-Lite: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign a_go = hsel && htrans[1] && hready;
   assign a_hit = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0);

   // Write slave: awlen is 8 bits so 256 beats is the longest burst accepted
   assign outst = {1'b0, aw_cnt_reg} + {1'b0, b_cnt_reg};
   assign mm_awready = (outst < (`CPAC_OUTST_AW+2)'(`CPAC_OUTST));
   assign mm_wready = (aw_cnt_reg != '0) && !wf_full;
   assign mm_bvalid = (b_cnt_reg != '0);
   assign mm_bresp = 2'h0;
   assign aw_hs = mm_awvalid && mm_awready;
   assign w_hs = mm_wvalid && mm_wready;
   assign w_last = w_hs && mm_wlast;
   assign b_hs = mm_bvalid && mm_bready;

   // Read slave: beats only while the memory-mapped port is chosen
   assign mm_arready = !aq_full;
   assign mm_rvalid = !strm && !aq_empty && !rf_empty;
   assign mm_rdata = rf_dout;
   assign mm_rlast = (beat_reg == aq_len);
   assign mm_rresp = 2'h0;
   assign r_hs = mm_rvalid && mm_rready;

   // Stream master: one open-ended packet, last only when the transfer is spent
   assign st_tvalid = strm && !rf_empty;
   assign st_tdata = rf_dout;
   assign st_tlast = (rf_cnt == (FAW+1)'(1)) && !rd_cmd && !cap_pend_reg;
   assign t_hs = st_tvalid && st_tready;

   // Primitive pins; a new access never starts under release so the current one is the last
   assign owned = access_gnt && access_req;
   assign wr_go = owned && !access_rel && !rd_cmd && !wf_empty && (remain_reg != '0);
   assign rd_go = owned && !access_rel && rd_cmd && (remain_reg != '0) && !rf_full && !cap_pend_reg;
   assign need = (remain_reg != '0) && (rd_cmd || !wf_empty);
   assign busy = !sel_n_reg || cap_pend_reg;
   assign prim_sel_n = sel_n_reg;
   assign prim_rd_nwr = rd_nwr_reg;
   assign prim_wdata = pwdata_reg;
   assign gate_prim_clk = rf_full;

   // Register file, sequencer and bus counters; hardware first, software write after it
   always_comb begin
      wr_pend_next = 1'b0;
      wr_ofs_next = wr_ofs_reg;
      hrdata_next = hrdata_reg;
      size_next = size_reg;
      remain_next = remain_reg;
      ctrl_next = ctrl_reg;
      sel_n_next = !(wr_go || rd_go);
      rd_nwr_next = rd_cmd;
      cap_pend_next = rd_go;
      pwdata_next = wr_go ? wf_dout : pwdata_reg;
      aw_cnt_next = aw_cnt_reg + (`CPAC_OUTST_AW+1)'(aw_hs) - (`CPAC_OUTST_AW+1)'(w_last);
      b_cnt_next = b_cnt_reg + (`CPAC_OUTST_AW+1)'(w_last) - (`CPAC_OUTST_AW+1)'(b_hs);
      beat_next = beat_reg;
      if (r_hs) begin
         beat_next = mm_rlast ? '0 : beat_reg + `CPAC_LEN_W'(1);
      end
      if (wr_go || rd_go) begin
         remain_next = remain_reg - `CPAC_SIZE_W'(1);
      end
      if (rd_go && (remain_reg == `CPAC_SIZE_W'(1))) begin
         ctrl_next[`CPAC_CTRL_RD] = 1'b0;
      end
      if (a_go) begin
         wr_pend_next = hwrite && a_hit;
         wr_ofs_next = haddr[7:0];
      end
      if (a_go && !hwrite) begin
         hrdata_next = 32'h0;
         if (a_hit) begin
            unique case (haddr[7:0])
               `CPAC_OFS_SIZE: hrdata_next = 32'(size_reg);
               `CPAC_OFS_CTRL: hrdata_next = 32'(ctrl_reg);
               `CPAC_OFS_STAT: hrdata_next = {26'h0, rf_full, wf_empty, access_gnt, access_req, busy,
                                              rd_cmd};
               `CPAC_OFS_WOCC: hrdata_next = 32'(wf_cnt);
               `CPAC_OFS_ROCC: hrdata_next = 32'(rf_cnt);
               `CPAC_OFS_REM: hrdata_next = 32'(remain_reg);
               default: hrdata_next = 32'h0;
            endcase
         end
      end
      // Software write lands in the data phase and wins over the hardware update
      if (wr_pend_reg) begin
         unique case (wr_ofs_reg)
            `CPAC_OFS_SIZE: begin
               size_next = hwdata[`CPAC_SIZE_W-1:0];
               remain_next = hwdata[`CPAC_SIZE_W-1:0];
            end
            `CPAC_OFS_CTRL: ctrl_next = hwdata[`CPAC_CTRL_W-1:0];
            default: ctrl_next = ctrl_next;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_ofs_reg <= 8'h00;
         hrdata_reg <= 32'h0;
         size_reg <= `CPAC_SIZE_RST;
         remain_reg <= `CPAC_SIZE_RST;
         ctrl_reg <= `CPAC_CTRL_RST;
         sel_n_reg <= 1'b1;
         rd_nwr_reg <= 1'b0;
         cap_pend_reg <= 1'b0;
         pwdata_reg <= 32'h0;
         aw_cnt_reg <= '0;
         b_cnt_reg <= '0;
         beat_reg <= '0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_ofs_reg <= wr_ofs_next;
         hrdata_reg <= hrdata_next;
         size_reg <= size_next;
         remain_reg <= remain_next;
         ctrl_reg <= ctrl_next;
         sel_n_reg <= sel_n_next;
         rd_nwr_reg <= rd_nwr_next;
         cap_pend_reg <= cap_pend_next;
         pwdata_reg <= pwdata_next;
         aw_cnt_reg <= aw_cnt_next;
         b_cnt_reg <= b_cnt_next;
         beat_reg <= beat_next;
      end
   end
endmodule : cpac_top

// [verification/cpac_props.sv]
// Purpose: Concurrent checks on the controller boundary
// Assumes: One clock, reset active low
// Notes:   Bound from the bench top file
`timescale 1ns/10ps
module cpac_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic mm_wvalid,
   input wire logic mm_wready,
   input wire logic mm_wlast,
   input wire logic mm_bvalid,
   input wire logic mm_bready,
   input wire logic mm_rvalid,
   input wire logic mm_rready,
   input wire logic [31:0] mm_rdata,
   input wire logic st_tvalid,
   input wire logic st_tready,
   input wire logic [31:0] st_tdata,
   input wire logic prim_sel_n,
   input wire logic prim_rd_nwr,
   input wire logic access_req,
   input wire logic access_gnt,
   input wire logic access_rel
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // A select needs grant, request and no release at its launch edge
   AST_SEL_OWNED: assert property (!prim_sel_n |-> $past(access_gnt && access_req && !access_rel))
      else $error("select without ownership");
   // Long release: in-flight word done, request down
   AST_REL_DROP: assert property (access_rel [*6] |-> !access_req)
      else $error("request held under release");
   // Gap after release falls
   AST_REL_GAP: assert property ($fell(access_rel) |-> !access_req [*4])
      else $error("request too soon after release");
   AST_DIR_RST: assert property ($rose(hresetn) |-> !prim_rd_nwr)
      else $error("direction not write after reset");
   // Request stays up past a select, since the access is still in flight
   AST_REQ_BUSY: assert property (!prim_sel_n && !access_rel |=> access_req)
      else $error("request dropped mid access");
   AST_R_HOLD: assert property (mm_rvalid && !mm_rready |=> mm_rvalid && $stable(mm_rdata))
      else $error("read beat changed while stalled");
   AST_T_HOLD: assert property (st_tvalid && !st_tready |=> st_tvalid && $stable(st_tdata))
      else $error("stream beat changed while stalled");
   AST_B_RESP: assert property (mm_wvalid && mm_wready && mm_wlast |=> mm_bvalid)
      else $error("no write response");
   AST_B_HOLD: assert property (mm_bvalid && !mm_bready |=> mm_bvalid)
      else $error("write response withdrawn");
   AST_ONE_PATH: assert property (!(mm_rvalid && st_tvalid))
      else $error("both read paths active");
   COV_STREAM: cover property (st_tvalid && st_tready);
   COV_MM_READ: cover property (mm_rvalid && mm_rready);
   COV_REL: cover property ($fell(access_rel));
endmodule : cpac_props

// [verification/cpac_arb_model.sv]
// Purpose: Arbiter grant and primitive model on the far side
// Assumes: Read word offered from the select cycle through the next one
// Notes:   Written words are logged for the bench
`timescale 1ns/10ps
module cpac_arb_model #(
   parameter logic [31:0] RD_BASE = 32'h5a000000
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] gnt_delay,
   input wire logic access_req,
   input wire logic prim_sel_n,
   input wire logic prim_rd_nwr,
   input wire logic [31:0] prim_wdata,
   output logic access_gnt,
   output logic [31:0] prim_rdata
);
   logic [3:0] wait_cnt;
   logic [31:0] cur_word;
   logic rd_due;
   logic [31:0] wlog [$];
   wire rd_sel = !prim_sel_n && prim_rd_nwr;
   // Inverted outside the window so stale data never matches
   assign prim_rdata = (rd_sel || rd_due) ? cur_word : ~cur_word;
   // Grant after a set wait, held until the request drops
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         access_gnt <= 1'b0;
         wait_cnt <= 4'h0;
         cur_word <= RD_BASE;
         rd_due <= 1'b0;
      end else begin
         rd_due <= rd_sel;
         if (rd_due) begin
            cur_word <= cur_word + 32'h1;
         end
         if (!prim_sel_n && !prim_rd_nwr) begin
            wlog.push_back(prim_wdata);
         end
         if (!access_req) begin
            access_gnt <= 1'b0;
            wait_cnt <= 4'h0;
         end else if (wait_cnt >= gnt_delay) begin
            access_gnt <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule : cpac_arb_model

// [verification/tb.sv]
// Purpose: Self-checking bench for the access controller
// Assumes: Control bus answers with no wait states
// Notes:   Read words count up from rd_base in the model
`timescale 1ns/10ps
`include "cpac_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb;
   localparam logic [31:0] rd_base = 32'h5a000000;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, mm_wdata = 32'h0, q, exp_rd = rd_base;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic mm_awvalid = 1'b0, mm_wvalid = 1'b0, mm_wlast = 1'b0, mm_bready = 1'b0;
   logic mm_arvalid = 1'b0, mm_rready = 1'b0, st_tready = 1'b0, access_rel = 1'b0;
   logic [7:0] mm_awlen = 8'h0, mm_arlen = 8'h0;
   logic [3:0] gnt_delay = 4'h0;
   logic hreadyout, hresp, mm_awready, mm_wready, mm_bvalid, mm_arready, mm_rvalid, mm_rlast;
   logic st_tvalid, st_tlast, prim_sel_n, prim_rd_nwr, access_req, access_gnt, gate_prim_clk;
   logic [31:0] hrdata, mm_rdata, st_tdata, prim_wdata, prim_rdata;
   logic [1:0] mm_bresp, mm_rresp;
   int checked = 0;
   int n_errors = 0;
   assign hready = hreadyout;
   always #50 hclk = ~hclk;
   cpac_top u_cpac_top (.*);
   cpac_arb_model #(.RD_BASE(rd_base)) u_cpac_arb_model (.*);
   task automatic stop_test();
      $display("Comparisons %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   // Steps edge by edge until s shows v; a hang ends the run
   task automatic hs(ref logic s, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
         if (n > 3000) begin
            n_errors++;
            stop_test();
         end
      end while (s !== v);
   endtask : hs
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= 32'(a);
      hwrite <= wr;
      htrans <= 2'h2;
      hs(hreadyout, 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      hs(hreadyout, 1'b1);
      r = hrdata;
   endtask : ahb
   task automatic mm_write(input int beats);
      mm_awvalid <= 1'b1;
      mm_awlen <= 8'(beats - 1);
      hs(mm_awready, 1'b1);
      mm_awvalid <= 1'b0;
      for (int i = 0; i < beats; i++) begin
         mm_wvalid <= 1'b1;
         mm_wdata <= 32'ha5000000 + 32'(i);
         mm_wlast <= (i == beats - 1);
         hs(mm_wready, 1'b1);
      end
      mm_wvalid <= 1'b0;
      mm_bready <= 1'b1;
      hs(mm_bvalid, 1'b1);
      `CHK(mm_bresp, 2'h0)
      mm_bready <= 1'b0;
   endtask : mm_write
   // Reads beats on the memory slave or the stream master, in order
   task automatic rd_beats(input int beats, input bit strm);
      mm_arvalid <= !strm;
      mm_arlen <= 8'(beats - 1);
      if (!strm) begin
         hs(mm_arready, 1'b1);
         mm_arvalid <= 1'b0;
         // First beat left stalled one cycle so the hold check has a wait to watch
         hs(mm_rvalid, 1'b1);
      end
      mm_rready <= !strm;
      st_tready <= strm;
      for (int i = 0; i < beats; i++) begin
         if (strm) begin
            hs(st_tvalid, 1'b1);
            `CHK(st_tdata, exp_rd)
            `CHK(st_tlast, i == beats - 1)
         end else begin
            hs(mm_rvalid, 1'b1);
            `CHK(mm_rdata, exp_rd)
            `CHK(mm_rlast, i == beats - 1)
            `CHK(mm_rresp, 2'h0)
         end
         exp_rd++;
      end
      mm_rready <= 1'b0;
      st_tready <= 1'b0;
   endtask : rd_beats
   task automatic t_reset();
      `CHK(prim_rd_nwr, 1'b0)
      `CHK(access_req, 1'b0)
      `CHK(gate_prim_clk, 1'b0)
      ahb(1'b1, 8'h40, 32'hffffffff, q);
      ahb(1'b0, 8'h40, 32'h0, q);
      `CHK(q, 32'h0)
      // Size counter is wide enough for the largest transfer, upper bits dropped
      ahb(1'b1, `CPAC_OFS_SIZE, 32'hffffffff, q);
      ahb(1'b0, `CPAC_OFS_SIZE, 32'h0, q);
      `CHK(q, 32'h1fffffff)
      `CHK(hresp, 1'b0)
   endtask : t_reset
   // Long burst, slow grant: words queue in the FIFO ahead of the grant, then drain in order
   task automatic t_write();
      gnt_delay <= 4'h8;
      ahb(1'b1, `CPAC_OFS_SIZE, 32'd256, q);
      mm_write(256);
      hs(access_req, 1'b0);
      `CHK(u_cpac_arb_model.wlog.size(), 256)
      for (int i = 0; i < 256; i++) begin
         `CHK(u_cpac_arb_model.wlog[i], 32'ha5000000 + 32'(i))
      end
      ahb(1'b0, `CPAC_OFS_REM, 32'h0, q);
      `CHK(q, 32'h0)
      gnt_delay <= 4'h0;
      // Write FIFO disabled: one word at a time still reaches the primitive in order
      ahb(1'b1, `CPAC_OFS_CTRL, 32'h8, q);
      ahb(1'b1, `CPAC_OFS_SIZE, 32'd2, q);
      mm_write(2);
      hs(access_req, 1'b0);
      `CHK(u_cpac_arb_model.wlog.size(), 258)
      `CHK(u_cpac_arb_model.wlog[257], 32'ha5000001)
      ahb(1'b1, `CPAC_OFS_CTRL, 32'h0, q);
   endtask : t_write
   // Reads by memory slave, by stream up to full, and with the read FIFO disabled
   task automatic t_read(input int words, input logic [31:0] ctrl, input logic [31:0] occ);
      ahb(1'b1, `CPAC_OFS_SIZE, 32'(words), q);
      ahb(1'b1, `CPAC_OFS_CTRL, ctrl, q);
      if (ctrl[`CPAC_CTRL_STRM]) begin
         hs(gate_prim_clk, 1'b1);
         ahb(1'b0, `CPAC_OFS_ROCC, 32'h0, q);
         `CHK(q, occ)
         `CHK(gate_prim_clk, 1'b1)
      end
      rd_beats(words, ctrl[`CPAC_CTRL_STRM]);
      ahb(1'b0, `CPAC_OFS_CTRL, 32'h0, q);
      `CHK(q[`CPAC_CTRL_RD], 1'b0)
   endtask : t_read
   // Lock holds the request; release drops it and a gap follows
   task automatic t_release();
      ahb(1'b1, `CPAC_OFS_CTRL, 32'h2, q);
      hs(access_req, 1'b1);
      repeat (3) @(posedge hclk);
      `CHK(access_req, 1'b1)
      access_rel <= 1'b1;
      repeat (8) @(posedge hclk);
      `CHK(access_req, 1'b0)
      access_rel <= 1'b0;
      @(posedge hclk);
      for (int i = 0; i < 4; i++) begin
         @(posedge hclk);
         `CHK(access_req, 1'b0)
      end
      hs(access_req, 1'b1);
      ahb(1'b1, `CPAC_OFS_CTRL, 32'h0, q);
      hs(access_req, 1'b0);
   endtask : t_release
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_write();
      t_read(4, 32'h1, 32'h0);
      t_read(33, 32'h5, 32'd32);
      t_read(2, 32'h15, 32'h1);
      t_release();
      stop_test();
   end
endmodule : tb
bind cpac_top cpac_props u_cpac_props (
   .hclk(hclk),
   .hresetn(hresetn),
   .mm_wvalid(mm_wvalid),
   .mm_wready(mm_wready),
   .mm_wlast(mm_wlast),
   .mm_bvalid(mm_bvalid),
   .mm_bready(mm_bready),
   .mm_rvalid(mm_rvalid),
   .mm_rready(mm_rready),
   .mm_rdata(mm_rdata),
   .st_tvalid(st_tvalid),
   .st_tready(st_tready),
   .st_tdata(st_tdata),
   .prim_sel_n(prim_sel_n),
   .prim_rd_nwr(prim_rd_nwr),
   .access_req(access_req),
   .access_gnt(access_gnt),
   .access_rel(access_rel)
);
